// File: design/vtsel_prio_cell.sv
// leaf: one request slot, pending test and priority compare against the running best
`timescale 1ns/10ps
module vtsel_prio_cell #(
    parameter int IDW = 6
) (
    input wire logic pending,
    input wire logic [2:0] level,
    input wire logic [IDW-1:0] my_id,
    input wire logic in_valid,
    input wire logic [2:0] in_level,
    input wire logic [IDW-1:0] in_id,
    output logic out_valid,
    output logic [2:0] out_level,
    output logic [IDW-1:0] out_id
);
    // chain runs high id to low; >= hands ties to the lower id
    logic take;
    always_comb begin
        take = pending && (level != 3'h0) && (!in_valid || level >= in_level);
        out_valid = in_valid || take;
        out_level = take ? level : in_level;
        out_id = take ? my_id : in_id;
    end
endmodule

// File: design/vtsel_top.sv
// main: vector table select, trap causes, peripheral flag/enable/priority map and vector fetch
`timescale 1ns/10ps
module vtsel_top #(
    parameter int NIRQ = vtsel_pkg::NUM_IRQ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic boot_segment_defined,
    input wire logic alt_table_disable_cfg,
    input wire logic [12:0] boot_segment_limit,
    input wire logic boot_segment_protect,
    input wire logic [NIRQ-1:0] irq_req,
    input wire logic osc_fail,
    input wire logic addr_error,
    input wire logic stack_error,
    input wire logic ecc_double_error,
    input wire logic ovf_a,
    input wire logic ovf_b,
    input wire logic cat_ovf_a,
    input wire logic cat_ovf_b,
    input wire logic shift_error,
    input wire logic div_zero,
    input wire logic [15:0] soft_trap_causes,
    input wire logic [2:0] cpu_level,
    input wire logic vec_ack,
    output logic vec_valid,
    output logic vec_is_trap,
    output logic [7:0] vec_num,
    output logic [23:0] vec_addr,
    output logic [23:0] program_counter,
    output logic alt_table_active,
    output logic [23:0] alt_table_base,
    output logic [23:0] alt_upper_half_base,
    output logic table_protect
);
    // ==================================================
    // elaboration checks
    if (NIRQ != vtsel_pkg::NUM_IRQ) begin : g_bad_nirq
        $error("request count must match the mapped table");
    end

    // ==================================================
    // registers
    logic [15:0] int_control_1;
    logic [15:0] int_control_2;
    logic [15:0] int_control_3;
    logic [15:0] int_control_4;
    logic [15:0] int_flag_reg [vtsel_pkg::NUM_FE_REGS];
    logic [15:0] int_enable_reg [vtsel_pkg::NUM_FE_REGS];
    logic [15:0] int_priority_reg [vtsel_pkg::NUM_PRI_REGS];
    vtsel_pkg::vtsel_state_e state;
    logic [15:0] next_ctrl1;
    logic [15:0] next_ctrl4;

    logic wr_c1, wr_c2, wr_c3, wr_c4;
    assign wr_c1 = reg_wr && reg_addr == vtsel_pkg::ADDR_CTRL1;
    assign wr_c2 = reg_wr && reg_addr == vtsel_pkg::ADDR_CTRL2;
    assign wr_c3 = reg_wr && reg_addr == vtsel_pkg::ADDR_CTRL3;
    assign wr_c4 = reg_wr && reg_addr == vtsel_pkg::ADDR_CTRL4;

    // ==================================================
    // trap causes: hardware set wins over a software clear
    logic math_a_en, math_b_en, math_c_en;
    always_comb begin
        math_a_en = int_control_1[vtsel_pkg::C1_OVAE];
        math_b_en = int_control_1[vtsel_pkg::C1_OVBE];
        math_c_en = int_control_1[vtsel_pkg::C1_COVE];
        next_ctrl1 = wr_c1 ? reg_wdata : int_control_1;
        if (osc_fail) next_ctrl1[vtsel_pkg::C1_OSC] = 1'b1;
        if (addr_error) next_ctrl1[vtsel_pkg::C1_ADR] = 1'b1;
        if (stack_error) next_ctrl1[vtsel_pkg::C1_STK] = 1'b1;
        if (ovf_a && math_a_en) next_ctrl1[vtsel_pkg::C1_OVA] = 1'b1;
        if (ovf_b && math_b_en) next_ctrl1[vtsel_pkg::C1_OVB] = 1'b1;
        if (cat_ovf_a && math_c_en) next_ctrl1[vtsel_pkg::C1_COVA] = 1'b1;
        if (cat_ovf_b && math_c_en) next_ctrl1[vtsel_pkg::C1_COVB] = 1'b1;
        if (shift_error && math_c_en) next_ctrl1[vtsel_pkg::C1_SFTE] = 1'b1;
        if (div_zero && math_c_en) next_ctrl1[vtsel_pkg::C1_DIVZ] = 1'b1;
        if ((ovf_a && math_a_en) || (ovf_b && math_b_en)
            || ((cat_ovf_a || cat_ovf_b || shift_error || div_zero) && math_c_en)) begin
            next_ctrl1[vtsel_pkg::C1_MATH] = 1'b1;
        end
    end

    always_comb begin
        next_ctrl4 = wr_c4 ? reg_wdata : int_control_4;
        if (ecc_double_error) next_ctrl4[vtsel_pkg::C4_DED] = 1'b1;
        // software trap request only counts while its enable is set
        if (wr_c4 && reg_wdata[vtsel_pkg::C4_SWTRAP] && !int_control_2[vtsel_pkg::C2_SWTRAP_EN]) begin
            next_ctrl4[vtsel_pkg::C4_SWTRAP] = 1'b0;
        end
    end

    // registers clear on reset, no controller involvement
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_control_1 <= 16'h0000;
            int_control_2 <= 16'h0000;
            int_control_3 <= 16'h0000;
            int_control_4 <= 16'h0000;
        end else begin
            int_control_1 <= next_ctrl1;
            int_control_2 <= wr_c2 ? reg_wdata : int_control_2;
            int_control_3 <= ((wr_c3 ? reg_wdata : int_control_3) | soft_trap_causes)
                             & vtsel_pkg::C3_SOFT_MASK;
            int_control_4 <= next_ctrl4;
        end
    end

    // ==================================================
    // peripheral flag / enable / priority map
    logic [vtsel_pkg::NUM_FE_REGS*16-1:0] impl_wide;
    assign impl_wide = {{(vtsel_pkg::NUM_FE_REGS*16-NIRQ){1'b0}}, vtsel_pkg::IRQ_IMPL};
    logic [vtsel_pkg::NUM_FE_REGS*16-1:0] irq_wide;
    assign irq_wide = {{(vtsel_pkg::NUM_FE_REGS*16-NIRQ){1'b0}}, irq_req};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int r = 0; r < vtsel_pkg::NUM_FE_REGS; r++) begin
                int_flag_reg[r] <= 16'h0000;
                int_enable_reg[r] <= 16'h0000;
            end
        end else begin
            for (int r = 0; r < vtsel_pkg::NUM_FE_REGS; r++) begin
                // set wins over clear; reserved slots stay zero
                int_flag_reg[r] <= (((reg_wr && reg_addr == vtsel_pkg::ADDR_FLAG0 + 5'(r))
                                    ? reg_wdata : int_flag_reg[r])
                                   | irq_wide[r*16 +: 16]) & impl_wide[r*16 +: 16];
                if (reg_wr && reg_addr == vtsel_pkg::ADDR_EN0 + 5'(r)) begin
                    int_enable_reg[r] <= reg_wdata & impl_wide[r*16 +: 16];
                end
            end
        end
    end

    // priority nibble mask keeps bit 3 of each field zero and reserved fields empty
    function automatic logic [15:0] pri_mask(input int r);
        logic [15:0] m;
        m = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            if (r*4 + k < NIRQ && vtsel_pkg::IRQ_IMPL[r*4 + k]) m[k*4 +: 4] = 4'h7;
        end
        return m;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int r = 0; r < vtsel_pkg::NUM_PRI_REGS; r++) int_priority_reg[r] <= 16'h0000;
        end else begin
            for (int r = 0; r < vtsel_pkg::NUM_PRI_REGS; r++) begin
                if (reg_wr && reg_addr == vtsel_pkg::ADDR_PRI0 + 5'(r)) begin
                    int_priority_reg[r] <= reg_wdata & pri_mask(r);
                end
            end
        end
    end

    // ==================================================
    // peripheral arbitration: chain from highest request down so ties go low
    logic [NIRQ:0] ch_valid;
    logic [2:0] ch_level [NIRQ+1];
    logic [5:0] ch_id [NIRQ+1];
    assign ch_valid[NIRQ] = 1'b0;
    assign ch_level[NIRQ] = 3'h0;
    assign ch_id[NIRQ] = 6'h00;

    genvar g;
    generate
        for (g = 0; g < NIRQ; g++) begin : g_cell
            vtsel_prio_cell #(.IDW(6)) u_cell (
                .pending(int_flag_reg[g/16][g%16] && int_enable_reg[g/16][g%16]),
                .level(int_priority_reg[g/4][(g%4)*4 +: 3]),
                .my_id(6'(g)),
                .in_valid(ch_valid[g+1]),
                .in_level(ch_level[g+1]),
                .in_id(ch_id[g+1]),
                .out_valid(ch_valid[g]),
                .out_level(ch_level[g]),
                .out_id(ch_id[g])
            );
        end
    endgenerate

    // ==================================================
    // trap arbitration by fixed priority
    logic trap_pend;
    logic [7:0] trap_vec;
    logic hard_pend;
    logic soft_pend;
    always_comb begin
        hard_pend = int_control_4[vtsel_pkg::C4_DED]
                    || (int_control_4[vtsel_pkg::C4_SWTRAP] && int_control_2[vtsel_pkg::C2_SWTRAP_EN]);
        soft_pend = |(int_control_3 & vtsel_pkg::C3_SOFT_MASK);
        trap_pend = 1'b1;
        if (int_control_1[vtsel_pkg::C1_OSC]) trap_vec = vtsel_pkg::VEC_OSC;
        else if (int_control_1[vtsel_pkg::C1_ADR]) trap_vec = vtsel_pkg::VEC_ADR;
        else if (hard_pend) trap_vec = vtsel_pkg::VEC_HARD;
        else if (int_control_1[vtsel_pkg::C1_STK]) trap_vec = vtsel_pkg::VEC_STK;
        else if (int_control_1[vtsel_pkg::C1_MATH]) trap_vec = vtsel_pkg::VEC_MATH;
        else if (soft_pend) trap_vec = vtsel_pkg::VEC_SOFT;
        else begin
            trap_vec = vtsel_pkg::VEC_OSC;
            trap_pend = 1'b0;
        end
    end

    // ==================================================
    // table selection
    logic alt_ok;
    logic [23:0] table_base;
    logic [23:0] last_page;
    always_comb begin
        // last page of the segment starts one page below the limit
        last_page = 24'(boot_segment_limit - 13'h0001) << vtsel_pkg::PAGE_SHIFT;
        alt_ok = boot_segment_defined && alt_table_disable_cfg
                 && int_control_2[vtsel_pkg::C2_ALT_EN]
                 && boot_segment_limit >= vtsel_pkg::BOOT_MIN_PAGES;
        table_base = alt_ok ? last_page : 24'h000000;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alt_table_active <= 1'b0;
            alt_table_base <= 24'h000000;
            alt_upper_half_base <= 24'h000000;
            table_protect <= 1'b0;
        end else begin
            alt_table_active <= alt_ok;
            alt_table_base <= last_page;
            // second half of the page is not for other content
            alt_upper_half_base <= last_page + (24'h000001 << (vtsel_pkg::PAGE_SHIFT - 1));
            table_protect <= boot_segment_protect;
        end
    end

    // ==================================================
    // vector fetch sequencer; cpu_level masks equal or lower user levels
    logic [7:0] next_vec;
    always_comb begin
        if (trap_pend) next_vec = trap_vec;
        else next_vec = vtsel_pkg::VEC_IRQ_BASE + 8'(ch_id[0]);
    end

    logic irq_go;
    assign irq_go = ch_valid[0] && ch_level[0] > cpu_level;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= vtsel_pkg::VT_IDLE;
            vec_valid <= 1'b0;
            vec_is_trap <= 1'b0;
            vec_num <= 8'h00;
            vec_addr <= vtsel_pkg::RESET_ADDR;
        end else begin
            case (state)
                vtsel_pkg::VT_IDLE: begin
                    if (trap_pend || irq_go) begin
                        state <= vtsel_pkg::VT_PRESENT;
                        vec_valid <= 1'b1;
                        vec_is_trap <= trap_pend;
                        vec_num <= next_vec;
                        vec_addr <= table_base + vtsel_pkg::TABLE_OFFSET + {15'h0000, next_vec, 1'b0};
                    end
                end
                vtsel_pkg::VT_PRESENT: begin
                    if (vec_ack) begin
                        state <= vtsel_pkg::VT_WAIT;
                        vec_valid <= 1'b0;
                    end
                end
                vtsel_pkg::VT_WAIT: begin
                    // one settle cycle so the cleared flag is seen before rearbitration
                    state <= vtsel_pkg::VT_IDLE;
                end
                default: begin
                    state <= vtsel_pkg::VT_IDLE;
                    vec_valid <= 1'b0;
                end
            endcase
        end
    end

    // program counter forced to zero by reset only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) program_counter <= vtsel_pkg::RESET_ADDR;
        else if (state == vtsel_pkg::VT_PRESENT && vec_ack) program_counter <= vec_addr;
    end

    // ==================================================
    // register read port, data one cycle after strobe
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        case (reg_addr)
            vtsel_pkg::ADDR_CTRL1: rd_mux = int_control_1;
            vtsel_pkg::ADDR_CTRL2: rd_mux = int_control_2;
            vtsel_pkg::ADDR_CTRL3: rd_mux = int_control_3;
            vtsel_pkg::ADDR_CTRL4: rd_mux = int_control_4;
            vtsel_pkg::ADDR_STAT: rd_mux = {13'h0000, alt_table_active, vec_valid, trap_pend};
            default: begin
                for (int r = 0; r < vtsel_pkg::NUM_FE_REGS; r++) begin
                    if (reg_addr == vtsel_pkg::ADDR_FLAG0 + 5'(r)) rd_mux = int_flag_reg[r];
                    if (reg_addr == vtsel_pkg::ADDR_EN0 + 5'(r)) rd_mux = int_enable_reg[r];
                end
                for (int r = 0; r < vtsel_pkg::NUM_PRI_REGS; r++) begin
                    if (reg_addr == vtsel_pkg::ADDR_PRI0 + 5'(r)) rd_mux = int_priority_reg[r];
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) reg_rdata <= 16'h0000;
        else reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
endmodule

// File: pkg/vtsel_pkg.sv
// package: register map, bit fields and vector constants
package vtsel_pkg;
    // register word indices on the plain register port
    localparam logic [4:0] ADDR_CTRL1 = 5'h00;
    localparam logic [4:0] ADDR_CTRL2 = 5'h01;
    localparam logic [4:0] ADDR_CTRL3 = 5'h02;
    localparam logic [4:0] ADDR_CTRL4 = 5'h03;
    localparam logic [4:0] ADDR_FLAG0 = 5'h04;
    localparam logic [4:0] ADDR_EN0 = 5'h08;
    localparam logic [4:0] ADDR_PRI0 = 5'h0C;
    localparam logic [4:0] ADDR_STAT = 5'h18;
    localparam int NUM_FE_REGS = 3;
    localparam int NUM_PRI_REGS = 11;
    localparam int NUM_IRQ = 43;
    // int_control_1 fields
    localparam int C1_OSC = 1;
    localparam int C1_STK = 2;
    localparam int C1_ADR = 3;
    localparam int C1_MATH = 4;
    localparam int C1_DIVZ = 6;
    localparam int C1_SFTE = 7;
    localparam int C1_COVE = 8;
    localparam int C1_OVBE = 9;
    localparam int C1_OVAE = 10;
    localparam int C1_COVB = 11;
    localparam int C1_COVA = 12;
    localparam int C1_OVB = 13;
    localparam int C1_OVA = 14;
    // int_control_2 fields
    localparam int C2_ALT_EN = 8;
    localparam int C2_SWTRAP_EN = 13;
    // int_control_3 soft trap causes
    localparam logic [15:0] C3_SOFT_MASK = 16'h8311;
    // int_control_4 fields
    localparam int C4_SWTRAP = 0;
    localparam int C4_DED = 1;
    // vector numbering and addresses
    localparam logic [7:0] VEC_OSC = 8'h00;
    localparam logic [7:0] VEC_ADR = 8'h01;
    localparam logic [7:0] VEC_HARD = 8'h02;
    localparam logic [7:0] VEC_STK = 8'h03;
    localparam logic [7:0] VEC_MATH = 8'h04;
    localparam logic [7:0] VEC_SOFT = 8'h06;
    localparam logic [7:0] VEC_IRQ_BASE = 8'h08;
    localparam logic [23:0] TABLE_OFFSET = 24'h000004;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    // trap priorities
    localparam logic [3:0] PRI_OSC = 4'hF;
    localparam logic [3:0] PRI_ADR = 4'hE;
    localparam logic [3:0] PRI_HARD = 4'hD;
    localparam logic [3:0] PRI_STK = 4'hC;
    localparam logic [3:0] PRI_MATH = 4'hB;
    localparam logic [3:0] PRI_SOFT = 4'h9;
    // reserved request numbers (vectors 13, 30, 40-42, 47, 50)
    localparam logic [NUM_IRQ-1:0] IRQ_IMPL = 43'h378_FFBF_FFDF;
    // boot segment geometry: one page is 1024 instruction words, 2048 addresses
    localparam int PAGE_SHIFT = 11;
    localparam logic [12:0] BOOT_MIN_PAGES = 13'h0002;
    // states of the vector fetch sequencer
    typedef enum logic [1:0] {VT_IDLE, VT_PRESENT, VT_WAIT} vtsel_state_e;
endpackage

// File: verification/vtsel_core_model.sv
// partner: core that acks presented vectors
`timescale 1ns/10ps
module vtsel_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic vec_valid,
    input wire logic slow,
    output logic vec_ack
);
    logic [2:0] wait_cnt;
    // unused slots are never presented, so no default handler is fetched
    // one-cycle ack pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 3'h0;
            vec_ack <= 1'b0;
        end else begin
            vec_ack <= 1'b0;
            if (vec_valid && !vec_ack) begin
                if (wait_cnt >= (slow ? 3'h4 : 3'h0)) begin
                    vec_ack <= 1'b1;
                    wait_cnt <= 3'h0;
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end
        end
    end
endmodule

// File: verification/vtsel_top_assertions.sv
// checker: port-level assertions
`timescale 1ns/10ps
module vtsel_top_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic boot_segment_defined,
    input wire logic [12:0] boot_segment_limit,
    input wire logic boot_segment_protect,
    input wire logic vec_ack,
    input wire logic vec_valid,
    input wire logic vec_is_trap,
    input wire logic [7:0] vec_num,
    input wire logic [23:0] vec_addr,
    input wire logic [23:0] program_counter,
    input wire logic alt_table_active,
    input wire logic [23:0] alt_table_base,
    input wire logic [23:0] alt_upper_half_base,
    input wire logic table_protect
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========================
    // vector hand-off
    a_reset_pc_zero: assert property ($past(rst) |-> program_counter == 24'h000000 && !vec_valid)
        else $error("counter not zero after reset");
    a_vec_holds: assert property (vec_valid && !vec_ack |=> vec_valid && $stable(vec_addr) && $stable(vec_num))
        else $error("vector changed before ack");
    a_pc_takes_vec: assert property (vec_valid && vec_ack |=> program_counter == $past(vec_addr) && !vec_valid)
        else $error("counter did not load vector");
    a_table_addr: assert property ($rose(vec_valid) |->
        vec_addr == (alt_table_active ? alt_table_base : 24'h000000) + 24'h000004 + {15'h0000, vec_num, 1'b0})
        else $error("vector address off table");
    a_trap_slots: assert property (vec_valid && vec_is_trap |-> vec_num < 8'h08 && vec_num != 8'h05 && vec_num != 8'h07)
        else $error("trap on bad slot");
    a_irq_not_reserved: assert property (vec_valid && !vec_is_trap |->
        vec_num >= 8'h08 && !(vec_num inside {8'h0D, 8'h1E, [8'h28:8'h2A], 8'h2F, 8'h32}))
        else $error("request on reserved vector");
    // ==========================
    // table placement
    a_primary_no_boot: assert property (!boot_segment_defined [*2] |-> !alt_table_active)
        else $error("alternate table without boot segment");
    a_alt_base_page: assert property (alt_table_active && $stable(boot_segment_limit) |->
        alt_table_base == {boot_segment_limit - 13'h0001, 11'h000})
        else $error("alternate base wrong");
    a_upper_half: assert property (alt_table_active |-> alt_upper_half_base == alt_table_base + 24'h000400)
        else $error("upper half base wrong");
    a_protect_copy: assert property ((boot_segment_defined && $stable(boot_segment_protect)) [*3] |->
        table_protect == boot_segment_protect)
        else $error("table protection differs");
    c_trap_taken: cover property (vec_valid && vec_ack && vec_is_trap);
    c_irq_taken: cover property (vec_valid && vec_ack && !vec_is_trap);
    c_alt_vector: cover property (alt_table_active && vec_valid);
endmodule

// File: verification/vtsel_top_tb.sv
// testbench: register, request and trap scenarios
`timescale 1ns/10ps
module vtsel_top_tb;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic boot_segment_defined = 1'b0, alt_table_disable_cfg = 1'b0, boot_segment_protect = 1'b0;
    logic osc_fail = 1'b0, addr_error = 1'b0, stack_error = 1'b0, ecc_double_error = 1'b0;
    logic ovf_a = 1'b0, ovf_b = 1'b0, cat_ovf_a = 1'b0, cat_ovf_b = 1'b0, shift_error = 1'b0, div_zero = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, soft_trap_causes = 16'h0000, reg_rdata;
    logic [12:0] boot_segment_limit = 13'h0000;
    logic [vtsel_pkg::NUM_IRQ-1:0] irq_req = '0;
    logic [2:0] cpu_level = 3'h0;
    logic vec_ack, vec_valid, vec_is_trap, alt_table_active, table_protect;
    logic [7:0] vec_num;
    logic [23:0] vec_addr, program_counter, alt_table_base, alt_upper_half_base;
    int bad_count = 0, total_checks = 0, k, n;
    int ns [5] = '{0, 13, 23, 24, 41};
    int tv [5] = '{0, 1, 3, 2, 6};
    int ty [6] = '{14, 13, 12, 11, 7, 6};
    logic [15:0] resv [3] = '{16'hFFDF, 16'hFFBF, 16'h0378};

    always #2 clk = ~clk;

    vtsel_top vtsel_top_i (.*);
    vtsel_core_model vtsel_core_model_i (.clk, .rst, .vec_valid, .slow, .vec_ack);

    // ==========================
    // shared tasks
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic give_up(input logic hit);
        if (hit) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    endtask
    // wait out re-presentations
    task automatic settle;
        int i;
        int q;
        q = 0;
        for (i = 0; i < 60 && q < 4; i++) begin
            @(posedge clk);
            #1;
            q = (vec_valid === 1'b0) ? q + 1 : 0;
        end
        give_up(q < 4);
    endtask
    task automatic take_vec(input logic [7:0] v, input logic [23:0] a, input logic trap);
        int i;
        for (i = 0; i < 60 && vec_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        give_up(i == 60);
        chk("vec_num", 24'(vec_num), 24'(v));
        chk("vec_addr", vec_addr, a);
        chk("vec_is_trap", 24'(vec_is_trap), 24'(trap));
        for (i = 0; i < 60 && vec_ack !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        give_up(i == 60);
        @(posedge clk);
        #1;
        chk("program_counter", program_counter, a);
    endtask

    // ==========================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("program_counter", program_counter, 24'h000000);
        rd(5'h1F, 16'h0000);
        for (k = 0; k < 3; k++) begin
            wr(vtsel_pkg::ADDR_EN0 + 5'(k), 16'hFFFF);
            rd(vtsel_pkg::ADDR_EN0 + 5'(k), resv[k]);
            wr(vtsel_pkg::ADDR_EN0 + 5'(k), 16'h0000);
        end
        wr(vtsel_pkg::ADDR_PRI0 + 5'h01, 16'h7777);
        rd(vtsel_pkg::ADDR_PRI0 + 5'h01, 16'h7707);
        $display("test map done");
        for (k = 0; k < 5; k++) begin
            n = ns[k];
            wr(vtsel_pkg::ADDR_EN0 + 5'(n / 16), 16'h0001 << (n % 16));
            wr(vtsel_pkg::ADDR_PRI0 + 5'(n / 4), 16'h0001 << (4 * (n % 4)));
            @(posedge clk);
            irq_req[n] <= 1'b1;
            @(posedge clk);
            irq_req[n] <= 1'b0;
            take_vec(8'(n + 8), 24'(2 * n + 20), 1'b0);
            rd(vtsel_pkg::ADDR_FLAG0 + 5'(n / 16), 16'h0001 << (n % 16));
            wr(vtsel_pkg::ADDR_FLAG0 + 5'(n / 16), 16'h0000);
            wr(vtsel_pkg::ADDR_EN0 + 5'(n / 16), 16'h0000);
            settle();
        end
        $display("test requests done");
        wr(vtsel_pkg::ADDR_EN0, 16'h0006);
        wr(vtsel_pkg::ADDR_PRI0, 16'h0110);
        cpu_level <= 3'h1;
        irq_req[2:1] <= 2'h3;
        @(posedge clk);
        irq_req[2:1] <= 2'h0;
        settle();
        chk("vec_valid", 24'(vec_valid), 24'h000000);
        cpu_level <= 3'h0;
        take_vec(8'h09, 24'h000016, 1'b0);
        cpu_level <= 3'h1;
        wr(vtsel_pkg::ADDR_FLAG0, 16'h0004);
        settle();
        cpu_level <= 3'h0;
        take_vec(8'h0A, 24'h000018, 1'b0);
        wr(vtsel_pkg::ADDR_FLAG0, 16'h0000);
        wr(vtsel_pkg::ADDR_EN0, 16'h0000);
        settle();
        $display("test tie done");
        slow <= 1'b1;
        for (k = 0; k < 5; k++) begin
            osc_fail <= (k == 0);
            addr_error <= (k < 2);
            stack_error <= (k < 3);
            ecc_double_error <= (k == 3);
            soft_trap_causes <= (k == 4) ? 16'h8000 : 16'h0000;
            @(posedge clk);
            {osc_fail, addr_error, stack_error, ecc_double_error} <= 4'h0;
            soft_trap_causes <= 16'h0000;
            take_vec(8'(tv[k]), 24'(2 * tv[k] + 4), 1'b1);
            wr(vtsel_pkg::ADDR_CTRL1, 16'h0000);
            wr(vtsel_pkg::ADDR_CTRL3, 16'h0000);
            wr(vtsel_pkg::ADDR_CTRL4, 16'h0000);
            settle();
        end
        slow <= 1'b0;
        {ovf_a, ovf_b, cat_ovf_a, cat_ovf_b, shift_error, div_zero} <= 6'h3F;
        @(posedge clk);
        {ovf_a, ovf_b, cat_ovf_a, cat_ovf_b, shift_error, div_zero} <= 6'h00;
        settle();
        rd(vtsel_pkg::ADDR_CTRL1, 16'h0000);
        for (k = 0; k < 6; k++) begin
            n = (k < 2) ? 10 - k : 8;
            wr(vtsel_pkg::ADDR_CTRL1, 16'h0001 << n);
            {ovf_a, ovf_b, cat_ovf_a, cat_ovf_b, shift_error, div_zero} <= 6'h20 >> k;
            @(posedge clk);
            {ovf_a, ovf_b, cat_ovf_a, cat_ovf_b, shift_error, div_zero} <= 6'h00;
            take_vec(8'h04, 24'h00000C, 1'b1);
            rd(vtsel_pkg::ADDR_CTRL1, (16'h0001 << ty[k]) | (16'h0001 << n) | 16'h0010);
            wr(vtsel_pkg::ADDR_CTRL1, 16'h0000);
            settle();
        end
        wr(vtsel_pkg::ADDR_CTRL4, 16'h0001);
        rd(vtsel_pkg::ADDR_CTRL4, 16'h0000);
        wr(vtsel_pkg::ADDR_CTRL2, 16'h2000);
        wr(vtsel_pkg::ADDR_CTRL4, 16'h0001);
        take_vec(8'h02, 24'h000008, 1'b1);
        wr(vtsel_pkg::ADDR_CTRL4, 16'h0000);
        wr(vtsel_pkg::ADDR_CTRL2, 16'h0000);
        settle();
        $display("test traps done");
        boot_segment_limit <= 13'h0004;
        alt_table_disable_cfg <= 1'b1;
        boot_segment_protect <= 1'b1;
        wr(vtsel_pkg::ADDR_CTRL2, 16'h0100);
        settle();
        chk("alt_table_active", 24'(alt_table_active), 24'h000000);
        boot_segment_defined <= 1'b1;
        settle();
        chk("alt_table_active", 24'(alt_table_active), 24'h000001);
        chk("alt_table_base", alt_table_base, 24'h001800);
        chk("alt_upper_half_base", alt_upper_half_base, 24'h001C00);
        chk("table_protect", 24'(table_protect), 24'h000001);
        osc_fail <= 1'b1;
        @(posedge clk);
        osc_fail <= 1'b0;
        take_vec(8'h00, 24'h001804, 1'b1);
        wr(vtsel_pkg::ADDR_CTRL1, 16'h0000);
        alt_table_disable_cfg <= 1'b0;
        settle();
        chk("alt_table_active", 24'(alt_table_active), 24'h000000);
        alt_table_disable_cfg <= 1'b1;
        boot_segment_limit <= 13'h0001;
        settle();
        chk("alt_table_active", 24'(alt_table_active), 24'h000000);
        $display("test alternate done");
        close_out();
    end
endmodule

bind vtsel_top vtsel_top_assertions vtsel_top_assertions_i (.*);
